// ==== src/pgb_gpio_bank.sv ====
// Upper parallel GPIO bank (pins 32 to 45) with an APB register interface.
`timescale 1ns/10ps
`default_nettype none
module pgb_gpio_bank
  import pgb_pkg::*;
#(
  parameter int PIN_COUNT = PGB_PIN_COUNT
)(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output var  logic [PIN_COUNT-1:0] pin_out,
  output var  logic [PIN_COUNT-1:0] pin_oe
);
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_function_enable_bit;
  logic [PIN_COUNT-1:0] pin_direction_bit;
  logic [PIN_COUNT-1:0] pin_level_bit;
  logic [1:0]           enable_spare;
  logic [1:0]           direction_spare;
  logic [1:0]           level_spare;
  logic [15:0]          bank2_enable_reg;
  logic [15:0]          bank2_direction_reg;
  logic [15:0]          bank2_level_reg;
  logic [PIN_COUNT-1:0] level_view;
  pgb_state_type        state;
  logic                 setup;
  logic                 wr_access;
  logic                 rd_access;
  logic                 hit_enable;
  logic                 hit_dir;
  logic                 hit_level;
  logic                 hit_any;
  logic [31:0]          next_prdata;
  logic                 lo_lane;
  logic                 hi_lane;

  pgb_pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Level capture at reset must wait for the synchroniser to fill, so the
  // level register is loaded from the pins a fixed delay after release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= PGB_ST_RESET;
    else
    begin
      case (state)
        PGB_ST_RESET: state <= PGB_ST_WAIT;
        PGB_ST_WAIT:  state <= PGB_ST_LOAD;
        PGB_ST_LOAD:  state <= PGB_ST_RUN;
        PGB_ST_RUN:   state <= PGB_ST_RUN;
        default:      state <= PGB_ST_RESET;
      endcase
    end
  end

  // Register fields are 16 bits wide; byte lanes 0 and 1 carry them.
  assign setup      = psel && !penable;
  assign hit_enable = (paddr[17:0] == PGB_ENABLE_ADDR) && (paddr[31:18] == '0);
  assign hit_dir    = (paddr[17:0] == PGB_DIR_ADDR) && (paddr[31:18] == '0);
  assign hit_level  = (paddr[17:0] == PGB_LEVEL_ADDR) && (paddr[31:18] == '0);
  assign hit_any    = hit_enable || hit_dir || hit_level;
  assign wr_access  = psel && penable && pready && pwrite && hit_any;
  assign rd_access  = setup && !pwrite;
  assign lo_lane    = pstrb[0];
  assign hi_lane    = pstrb[1];

  assign bank2_enable_reg    = {enable_spare, pin_function_enable_bit};
  assign bank2_direction_reg = {direction_spare, pin_direction_bit};
  // Input pins read the sampled level, output pins read back the stored level.
  assign level_view      = (pin_direction_bit & pin_level_bit) | (~pin_direction_bit & pin_sync);
  assign bank2_level_reg = {level_spare, level_view};

  // No wait states: pready rises in the first access cycle, so reads are
  // prepared during setup and every transfer completes in two cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !hit_any;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_enable)
      next_prdata = {16'h0000, bank2_enable_reg};
    else if (hit_dir)
      next_prdata = {16'h0000, bank2_direction_reg};
    else if (hit_level)
      next_prdata = {16'h0000, bank2_level_reg};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_access)
      prdata <= next_prdata;
    else if (setup)
      prdata <= 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_function_enable_bit <= PGB_ENABLE_RESET[PIN_COUNT-1:0];
      enable_spare            <= PGB_RESERVED_RESET;
    end
    else if (wr_access && hit_enable)
    begin
      if (lo_lane)
        pin_function_enable_bit[7:0] <= pwdata[7:0];
      if (hi_lane)
      begin
        pin_function_enable_bit[PIN_COUNT-1:8] <= pwdata[PIN_COUNT-1:8];
        enable_spare <= pwdata[15:14];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction_bit <= PGB_DIR_RESET[PIN_COUNT-1:0];
      direction_spare   <= PGB_RESERVED_RESET;
    end
    else if (wr_access && hit_dir)
    begin
      if (lo_lane)
        pin_direction_bit[7:0] <= pwdata[7:0];
      if (hi_lane)
      begin
        pin_direction_bit[PIN_COUNT-1:8] <= pwdata[PIN_COUNT-1:8];
        direction_spare <= pwdata[15:14];
      end
    end
  end

  // Stored level bits load from the synchronised pins at the third edge after
  // reset, once both synchroniser stages hold real pin levels. A write that
  // completes at that same edge is applied after the capture and wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_level_bit <= '0;
      level_spare   <= PGB_RESERVED_RESET;
    end
    else
    begin
      if (state == PGB_ST_LOAD)
        pin_level_bit <= pin_sync;
      if (wr_access && hit_level)
      begin
        if (lo_lane)
          pin_level_bit[7:0] <= pwdata[7:0];
        if (hi_lane)
        begin
          pin_level_bit[PIN_COUNT-1:8] <= pwdata[PIN_COUNT-1:8];
          level_spare <= pwdata[15:14];
        end
      end
    end
  end

  // Pin drivers per bit; disabled or input pins are released.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_oe[gi]  <= 1'b0;
          pin_out[gi] <= 1'b0;
        end
        else
        begin
          pin_oe[gi]  <= pin_function_enable_bit[gi] && pin_direction_bit[gi];
          pin_out[gi] <= pin_level_bit[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== src/pgb_pkg.sv ====
// Package with register indices, field layout and reset values of the upper GPIO bank.
package pgb_pkg;
  localparam int          PGB_PIN_COUNT     = 14;
  localparam int          PGB_REG_WIDTH     = 16;
  localparam int          PGB_FIRST_PIN     = 32;
  // Printed offsets are word indices; the byte address is four times the index.
  localparam logic [15:0] PGB_ENABLE_INDEX  = 16'h4406;
  localparam logic [15:0] PGB_DIR_INDEX     = 16'h4407;
  localparam logic [15:0] PGB_LEVEL_INDEX   = 16'h4408;
  localparam logic [17:0] PGB_ENABLE_ADDR   = {PGB_ENABLE_INDEX, 2'b00};
  localparam logic [17:0] PGB_DIR_ADDR      = {PGB_DIR_INDEX, 2'b00};
  localparam logic [17:0] PGB_LEVEL_ADDR    = {PGB_LEVEL_INDEX, 2'b00};
  localparam logic [15:0] PGB_ENABLE_RESET  = 16'h0000;
  localparam logic [15:0] PGB_DIR_RESET     = 16'h0000;
  localparam logic [1:0]  PGB_RESERVED_RESET = 2'h0;
  localparam int          PGB_SYNC_STAGES   = 2;
  localparam int          PGB_CAPTURE_DELAY = 2;
  typedef enum logic [1:0] {
    PGB_ST_RESET   = 2'b00,
    PGB_ST_WAIT    = 2'b01,
    PGB_ST_LOAD    = 2'b11,
    PGB_ST_RUN     = 2'b10
  } pgb_state_type;
endpackage

// ==== src/pgb_pin_sync.sv ====
// Two-stage synchroniser for the pin levels of the bank.
`timescale 1ns/10ps
`default_nettype none
module pgb_pin_sync
  import pgb_pkg::*;
#(
  parameter int WIDTH = 14
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== test/pgb_ext_model.sv ====
// Model of the outside circuitry that shares the bank's pins.
`timescale 1ns/10ps
`default_nettype none
module pgb_ext_model
  import pgb_pkg::*;
(
  input  wire logic [PGB_PIN_COUNT-1:0] ext_val,
  input  wire logic [PGB_PIN_COUNT-1:0] pin_out,
  input  wire logic [PGB_PIN_COUNT-1:0] pin_oe,
  output var  logic [PGB_PIN_COUNT-1:0] pin_in
);
  // A released pin follows the outside source, so a stale device level can never leak back in.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// ==== test/pgb_gpio_bank_chk.sv ====
// Checker with port-level assertions for the upper GPIO bank.
`timescale 1ns/10ps
`default_nettype none
module pgb_gpio_bank_chk
  import pgb_pkg::*;
#(
  parameter int PIN_COUNT = PGB_PIN_COUNT
)(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_any = psel & penable & pready & pwrite;
  wire logic wr    = wr_any & (pstrb[1:0] == 2'b11);
  wire logic w_cfg = wr_any & ((paddr == 32'(PGB_ENABLE_ADDR)) | (paddr == 32'(PGB_DIR_ADDR)));
  wire logic w_en  = wr & (paddr == 32'(PGB_ENABLE_ADDR));
  wire logic w_dir = wr & (paddr == 32'(PGB_DIR_ADDR));
  wire logic w_lvl = wr & (paddr == 32'(PGB_LEVEL_ADDR));
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RST_OFF: assert property ($rose(presetn) |-> pin_oe == '0)
    else $error("pin driven after reset");
  AST_OE_HOLD: assert property (!$past(w_cfg) |=> $stable(pin_oe))
    else $error("pin_oe changed without a write");
  AST_LVL_OUT: assert property (w_lvl |=> ##1 pin_out == $past(pwdata[PIN_COUNT-1:0], 2))
    else $error("pin_out differs from written level");
  AST_EN_GATE: assert property (w_en |=> ##1 (pin_oe & ~$past(pwdata[PIN_COUNT-1:0], 2)) == '0)
    else $error("disabled pin driven");
  AST_DIR_GATE: assert property (w_dir |=> ##1 (pin_oe & ~$past(pwdata[PIN_COUNT-1:0], 2)) == '0)
    else $error("input pin driven");
  AST_HIGH_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
endmodule
bind pgb_gpio_bank pgb_gpio_bank_chk #(.PIN_COUNT(PIN_COUNT)) i_pgb_gpio_bank_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pin_out, .pin_oe);
`default_nettype wire

// ==== test/pgb_gpio_bank_tb.sv ====
// Self-checking bench for the upper GPIO bank.
`timescale 1ns/10ps
`default_nettype none
module pgb_gpio_bank_tb
  import pgb_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr;
  logic [13:0] ext_val = 14'h0, pin_in, pin_out, pin_oe;
  logic [15:0] en, dir, lvl;
  logic [32:0] exp_q[$];
  int          bad_count = 0, tests_run = 0, seed = 38;
  always #2.5 pclk = ~pclk;
  pgb_gpio_bank i_pgb_gpio_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
  pgb_ext_model i_pgb_ext_model (.ext_val, .pin_out, .pin_oe, .pin_in);
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // The expected word is queued before the read so the monitor always finds it.
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk("read word", {pslverr, prdata}, exp_q.pop_front());
  task automatic do_reset();
    presetn <= 1'b0;
    ext_val <= 14'($random(seed));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("pin_oe", 33'(pin_oe), 33'h0);
    rd(32'(PGB_ENABLE_ADDR), 33'h0);
    rd(32'(PGB_DIR_ADDR), 33'h0);
    rd(32'(PGB_LEVEL_ADDR), 33'(ext_val));
    // Outputs still disabled: the stored level must be the one captured at reset.
    apb(1'b1, 32'(PGB_DIR_ADDR), 32'h0000_3fff);
    repeat (2) @(posedge pclk);
    chk("pin_oe", 33'(pin_oe), 33'h0);
    chk("pin_out", 33'(pin_out), 33'(ext_val));
    rd(32'(PGB_LEVEL_ADDR), 33'(ext_val));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    do_reset();
    repeat (6)
    begin
      en = 16'($random(seed));
      dir = 16'($random(seed));
      lvl = 16'($random(seed));
      ext_val <= 14'($random(seed));
      apb(1'b1, 32'(PGB_ENABLE_ADDR), 32'(en));
      apb(1'b1, 32'(PGB_DIR_ADDR), 32'(dir));
      apb(1'b1, 32'(PGB_LEVEL_ADDR), 32'(lvl));
      repeat (2) @(posedge pclk);
      chk("pin_oe", 33'(pin_oe), 33'(en[13:0] & dir[13:0]));
      chk("pin_out", 33'(pin_out & pin_oe), 33'(lvl[13:0] & en[13:0] & dir[13:0]));
      rd(32'(PGB_ENABLE_ADDR), 33'(en));
      rd(32'(PGB_DIR_ADDR), 33'(dir));
      rd(32'(PGB_LEVEL_ADDR), 33'({lvl[15:14], (dir[13:0] & lvl[13:0]) | (~dir[13:0] & ext_val)}));
    end
    // Only byte lane 1 is written; the low byte keeps its earlier value.
    pstrb <= 4'h2;
    apb(1'b1, 32'(PGB_ENABLE_ADDR), 32'h0000_ffff);
    pstrb <= 4'hf;
    rd(32'(PGB_ENABLE_ADDR), 33'({8'hff, en[7:0]}));
    apb(1'b1, 32'h11024, 32'hffff);
    rd(32'h11024, 33'h100000000);
    do_reset();
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
